// >>> design/walker_pkg.sv
// Constants, register map, descriptor layout and state types for the chain walker.
// Assumes a little-endian 64-bit memory word: byte 0 of the word sits in bits 7:0.
package walker_pkg;

  // Register port widths
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  // Register byte offsets
  localparam logic [REG_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFF_QSIZE = 8'h04;
  localparam logic [REG_AW-1:0] OFF_DESC_LO = 8'h08;
  localparam logic [REG_AW-1:0] OFF_DESC_HI = 8'h0C;
  localparam logic [REG_AW-1:0] OFF_AVAIL_LO = 8'h10;
  localparam logic [REG_AW-1:0] OFF_AVAIL_HI = 8'h14;
  localparam logic [REG_AW-1:0] OFF_STATUS = 8'h18;
  localparam logic [REG_AW-1:0] OFF_INDEX = 8'h1C;
  localparam logic [REG_AW-1:0] OFF_USED_LO = 8'h20;
  localparam logic [REG_AW-1:0] OFF_USED_HI = 8'h24;
  localparam logic [REG_AW-1:0] OFF_NOTIFY = 8'h28;

  // Control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LEGACY_BIT = 1;
  localparam int CTRL_BIGEND_BIT = 2;
  localparam int CTRL_INDFEAT_BIT = 3;

  // Status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_CODE_LSB = 4;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] QSIZE_RST = 16'h0100;
  localparam logic [63:0] BASE_RST = 64'h0;

  // Descriptor and ring layout
  localparam logic [15:0] FLAG_NEXT = 16'h0001;
  localparam logic [15:0] FLAG_WRITE = 16'h0002;
  localparam logic [15:0] FLAG_INDIRECT = 16'h0004;
  localparam logic [63:0] DESC_HALF_OFS = 64'h0000_0000_0000_0008;
  localparam logic [63:0] AVAIL_IDX_OFS = 64'h0000_0000_0000_0002;
  localparam logic [63:0] AVAIL_RING_OFS = 64'h0000_0000_0000_0004;
  localparam logic [63:0] AVAIL_TAIL_BYTES = 64'h0000_0000_0000_0006;
  localparam logic [16:0] QSIZE_MAX = 17'h08000;
  localparam int QALIGN_DEF = 4096;

  // Walker states
  typedef enum logic [2:0] {
    S_IDLE, S_IDX, S_HEAD, S_D0, S_D1, S_DECIDE, S_EMIT, S_ERR
  } walk_state_t;

  // Fault codes shown in status
  typedef enum logic [3:0] {
    ERR_NONE, ERR_RANGE, ERR_LONG, ERR_NEST, ERR_IND_NEXT, ERR_IND_FEAT, ERR_IND_LEN, ERR_ORDER
  } err_t;

endpackage

// >>> design/desc_fields.sv
// Splits a fetched 16-byte descriptor into address, length, flags and link.
// Assumes both halves were captured by the walker; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module desc_fields (
  input wire logic [63:0] word_lo,
  input wire logic [63:0] word_hi,
  input wire logic swap,
  output logic [63:0] buf_addr,
  output logic [31:0] buf_len,
  output logic [15:0] flags,
  output logic [15:0] link
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte reversal of one field, used for legacy big-endian guests
  function automatic logic [63:0] rev64(input logic [63:0] w);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 8; i++) begin
      r[i*8 +: 8] = w[(7-i)*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] w);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = w[(3-i)*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] w);
    return {w[7:0], w[15:8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Record order: address, length, flags, link
  always_comb begin
    buf_addr = swap ? rev64(word_lo) : word_lo;
    buf_len = swap ? rev32(word_hi[31:0]) : word_hi[31:0];
    flags = swap ? rev16(word_hi[47:32]) : word_hi[47:32];
    link = swap ? rev16(word_hi[63:48]) : word_hi[63:48];
  end

endmodule // desc_fields
`default_nettype wire

// >>> design/descriptor_chain_walker.sv
// Walks descriptor chains offered through the available ring and hands out buffers.
// Assumes a memory read port that answers each held request with one 64-bit word,
// and a buffer consumer that may stall with buf_ready.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module descriptor_chain_walker #(
  parameter int QALIGN = walker_pkg::QALIGN_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [walker_pkg::REG_AW-1:0] reg_addr,
  input wire logic [walker_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [walker_pkg::REG_DW-1:0] reg_rdata,
  output logic mem_req,
  output logic [63:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata,
  output logic buf_valid,
  input wire logic buf_ready,
  output logic [63:0] buf_addr,
  output logic [31:0] buf_len,
  output logic buf_dev_writes,
  output logic buf_last,
  output logic [15:0] buf_head
);
  import walker_pkg::*;

  localparam logic [63:0] QALIGN_M1 = 64'(QALIGN - 1);

  // Software-visible configuration
  logic en_r, legacy_r, bigend_r, indfeat_r;
  logic [15:0] qsz_r;
  logic [63:0] desc_base_r, avail_base_r;
  logic [REG_DW-1:0] rdata_r;

  // Walker state
  walk_state_t state_r;
  err_t err_r;
  logic mem_req_r;
  logic [63:0] mem_addr_r;
  logic [1:0] lane_r;
  logic [15:0] consumed_r, pub_r, head_r, cur_idx_r;
  logic in_ind_r, seen_wr_r, kick_r;
  logic [63:0] ind_base_r, raw_lo_r, raw_hi_r;
  logic [31:0] ind_cnt_r, tcnt_r;
  logic buf_valid_r, buf_wr_r, buf_last_r;
  logic [63:0] buf_addr_r;
  logic [31:0] buf_len_r;

  // Derived values
  logic swap;
  logic [63:0] ring_base, tbl_base, fetch_addr, used_base, avail_end;
  logic [15:0] slot, ring_val, d_flags, d_link;
  logic [63:0] d_addr;
  logic [31:0] d_len, tbl_entries;
  logic f_next, f_write, f_ind;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Picks one 16-bit ring field out of a fetched word
  function automatic logic [15:0] ring16(input logic [63:0] w, input logic [1:0] lane, input logic sw);
    logic [15:0] s;
    s = w[{lane, 4'h0} +: 16];
    return sw ? {s[7:0], s[15:8]} : s;
  endfunction

  function automatic logic is_pow2(input logic [15:0] v);
    return (v != 16'h0) && ((v & (v - 16'h1)) == 16'h0) && ({1'b0, v} <= QSIZE_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Layout and addressing
  assign swap = legacy_r & bigend_r;
  assign ring_base = legacy_r ? desc_base_r + {44'h0, qsz_r, 4'h0} : avail_base_r;
  assign avail_end = ring_base + AVAIL_TAIL_BYTES + {47'h0, qsz_r, 1'b0};
  assign used_base = legacy_r ? ((avail_end + QALIGN_M1) & ~QALIGN_M1) : 64'h0;
  assign slot = consumed_r & (qsz_r - 16'h1);
  assign tbl_base = in_ind_r ? ind_base_r : desc_base_r;
  assign tbl_entries = in_ind_r ? ind_cnt_r : {16'h0, qsz_r};
  assign ring_val = ring16(mem_rdata, lane_r, swap);

  // Byte address of the field the current state wants
  always_comb begin
    unique case (state_r)
      S_IDX: fetch_addr = ring_base + AVAIL_IDX_OFS;
      S_HEAD: fetch_addr = ring_base + AVAIL_RING_OFS + {47'h0, slot, 1'b0};
      S_D1: fetch_addr = tbl_base + {44'h0, cur_idx_r, 4'h0} + DESC_HALF_OFS;
      default: fetch_addr = tbl_base + {44'h0, cur_idx_r, 4'h0};
    endcase
  end

  desc_fields u_fields (
    .word_lo(raw_lo_r),
    .word_hi(raw_hi_r),
    .swap(swap),
    .buf_addr(d_addr),
    .buf_len(d_len),
    .flags(d_flags),
    .link(d_link)
  );

  assign f_next = (d_flags & FLAG_NEXT) != 16'h0;
  assign f_write = (d_flags & FLAG_WRITE) != 16'h0;
  assign f_ind = (d_flags & FLAG_INDIRECT) != 16'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; an illegal queue size is ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {indfeat_r, bigend_r, legacy_r, en_r} <= CTRL_RST;
      qsz_r <= QSIZE_RST;
      desc_base_r <= BASE_RST;
      avail_base_r <= BASE_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_CTRL: begin
          en_r <= reg_wdata[CTRL_EN_BIT];
          legacy_r <= reg_wdata[CTRL_LEGACY_BIT];
          bigend_r <= reg_wdata[CTRL_BIGEND_BIT];
          indfeat_r <= reg_wdata[CTRL_INDFEAT_BIT];
        end
        OFF_QSIZE: if (is_pow2(reg_wdata[15:0])) begin
          qsz_r <= reg_wdata[15:0];
        end
        OFF_DESC_LO: desc_base_r[31:0] <= reg_wdata;
        OFF_DESC_HI: desc_base_r[63:32] <= reg_wdata;
        OFF_AVAIL_LO: avail_base_r[31:0] <= reg_wdata;
        OFF_AVAIL_HI: avail_base_r[63:32] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (!reg_rd) begin
      rdata_r <= 32'h0;
    end else begin
      unique case (reg_addr)
        OFF_CTRL: rdata_r <= {28'h0, indfeat_r, bigend_r, legacy_r, en_r};
        OFF_QSIZE: rdata_r <= {16'h0, qsz_r};
        OFF_DESC_LO: rdata_r <= desc_base_r[31:0];
        OFF_DESC_HI: rdata_r <= desc_base_r[63:32];
        OFF_AVAIL_LO: rdata_r <= avail_base_r[31:0];
        OFF_AVAIL_HI: rdata_r <= avail_base_r[63:32];
        OFF_STATUS: rdata_r <= {24'h0, err_r, 2'b00, err_r != ERR_NONE, state_r != S_IDLE};
        OFF_INDEX: rdata_r <= {pub_r, consumed_r};
        OFF_USED_LO: rdata_r <= used_base[31:0];
        OFF_USED_HI: rdata_r <= used_base[63:32];
        default: rdata_r <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Walker: ring index, head, descriptor halves, decision, hand-out.
  // Memory is only ever read, and only descriptor and ring words: payload
  // is never touched here, the consumer moves it by direction.
  // Disable waits for an outstanding read so no answer is stranded.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      err_r <= ERR_NONE;
      mem_req_r <= 1'b0;
      mem_addr_r <= 64'h0;
      lane_r <= 2'h0;
      consumed_r <= 16'h0;
      pub_r <= 16'h0;
      head_r <= 16'h0;
      cur_idx_r <= 16'h0;
      in_ind_r <= 1'b0;
      seen_wr_r <= 1'b0;
      kick_r <= 1'b0;
      ind_base_r <= 64'h0;
      ind_cnt_r <= 32'h0;
      tcnt_r <= 32'h0;
      raw_lo_r <= 64'h0;
      raw_hi_r <= 64'h0;
      buf_valid_r <= 1'b0;
      buf_wr_r <= 1'b0;
      buf_last_r <= 1'b0;
      buf_addr_r <= 64'h0;
      buf_len_r <= 32'h0;
    end else if (!en_r && (!mem_req_r || mem_rvalid)) begin
      state_r <= S_IDLE;
      err_r <= ERR_NONE;
      mem_req_r <= 1'b0;
      consumed_r <= 16'h0;
      pub_r <= 16'h0;
      kick_r <= 1'b0;
      buf_valid_r <= 1'b0;
    end else begin
      // Doorbell: a write during the idle transition still counts
      if (reg_wr && reg_addr == OFF_NOTIFY && state_r != S_IDLE) begin
        kick_r <= 1'b1;
      end else if (state_r == S_IDLE && en_r) begin
        kick_r <= 1'b0;
      end
      unique case (state_r)
        S_IDLE: if (en_r && (kick_r || (reg_wr && reg_addr == OFF_NOTIFY))) begin
          state_r <= S_IDX;
        end
        S_IDX, S_HEAD, S_D0, S_D1: if (!mem_req_r) begin
          if (en_r) begin
            mem_req_r <= 1'b1;
            mem_addr_r <= {fetch_addr[63:3], 3'h0};
            lane_r <= fetch_addr[2:1];
          end
        end else if (mem_rvalid) begin
          mem_req_r <= 1'b0;
          if (state_r == S_IDX) begin
            pub_r <= ring_val;
            state_r <= (ring_val == consumed_r) ? S_IDLE : S_HEAD;
          end else if (state_r == S_HEAD) begin
            head_r <= ring_val;
            cur_idx_r <= ring_val;
            in_ind_r <= 1'b0;
            seen_wr_r <= 1'b0;
            tcnt_r <= 32'h0;
            if ({16'h0, ring_val} < {16'h0, qsz_r}) begin
              state_r <= S_D0;
            end else begin
              err_r <= ERR_RANGE;
              state_r <= S_ERR;
            end
          end else if (state_r == S_D0) begin
            raw_lo_r <= mem_rdata;
            state_r <= S_D1;
          end else begin
            raw_hi_r <= mem_rdata;
            state_r <= S_DECIDE;
          end
        end
        S_DECIDE: begin
          if (tcnt_r >= tbl_entries) begin
            err_r <= ERR_LONG;
            state_r <= S_ERR;
          end else if (f_ind) begin
            // Write flag of this descriptor plays no part
            if (in_ind_r) begin
              err_r <= ERR_NEST;
              state_r <= S_ERR;
            end else if (f_next) begin
              err_r <= ERR_IND_NEXT;
              state_r <= S_ERR;
            end else if (!indfeat_r) begin
              err_r <= ERR_IND_FEAT;
              state_r <= S_ERR;
            end else if (d_len == 32'h0 || d_len[3:0] != 4'h0) begin
              err_r <= ERR_IND_LEN;
              state_r <= S_ERR;
            end else begin
              ind_base_r <= d_addr;
              ind_cnt_r <= {4'h0, d_len[31:4]};
              in_ind_r <= 1'b1;
              cur_idx_r <= 16'h0;
              tcnt_r <= 32'h0;
              state_r <= S_D0;
            end
          end else if (seen_wr_r && !f_write) begin
            err_r <= ERR_ORDER;
            state_r <= S_ERR;
          end else begin
            buf_valid_r <= 1'b1;
            buf_addr_r <= d_addr;
            buf_len_r <= d_len;
            buf_wr_r <= f_write;
            buf_last_r <= !f_next;
            seen_wr_r <= seen_wr_r | f_write;
            tcnt_r <= tcnt_r + 32'h1;
            state_r <= S_EMIT;
          end
        end
        S_EMIT: if (buf_ready) begin
          buf_valid_r <= 1'b0;
          if (buf_last_r) begin
            consumed_r <= consumed_r + 16'h1;
            state_r <= S_IDX;
          end else if ({16'h0, d_link} < tbl_entries) begin
            cur_idx_r <= d_link;
            state_r <= S_D0;
          end else begin
            err_r <= ERR_RANGE;
            state_r <= S_ERR;
          end
        end
        S_ERR: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign reg_rdata = rdata_r;
  assign mem_req = mem_req_r;
  assign mem_addr = mem_addr_r;
  assign buf_valid = buf_valid_r;
  assign buf_addr = buf_addr_r;
  assign buf_len = buf_len_r;
  assign buf_dev_writes = buf_wr_r;
  assign buf_last = buf_last_r;
  assign buf_head = head_r;

endmodule // descriptor_chain_walker
`default_nettype wire

// >>> sim/walker_props.sv
// Port-level checker for the chain walker.
// Assumes it is bound into descriptor_chain_walker and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module walker_props #(
  parameter int QALIGN = walker_pkg::QALIGN_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [walker_pkg::REG_AW-1:0] reg_addr,
  input wire logic [walker_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [walker_pkg::REG_DW-1:0] reg_rdata,
  input wire logic mem_req,
  input wire logic [63:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata,
  input wire logic buf_valid,
  input wire logic buf_ready,
  input wire logic [63:0] buf_addr,
  input wire logic [31:0] buf_len,
  input wire logic buf_dev_writes,
  input wire logic buf_last,
  input wire logic [15:0] buf_head
);
  import walker_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Writable buffer already taken in this chain; a restart clears it too,
  // since an aborted chain never reaches its last buffer
  logic wr_seen_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen_r <= 1'b0;
    end else if ((buf_valid && buf_ready && buf_last) || (reg_wr && reg_addr == OFF_CTRL)) begin
      wr_seen_r <= 1'b0;
    end else if (buf_valid && buf_ready && buf_dev_writes) begin
      wr_seen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Handshake steps
  sequence s_wait; mem_req && !mem_rvalid; endsequence
  sequence s_answer; mem_req && mem_rvalid; endsequence
  sequence s_offer; buf_valid && !buf_ready; endsequence
  sequence s_take; buf_valid && buf_ready; endsequence
  sequence s_quiet; !buf_valid && !mem_req ##1 !buf_valid; endsequence
  sequence s_held; buf_valid && $stable({buf_addr, buf_len, buf_dev_writes, buf_last, buf_head}); endsequence

  AST_REQ_HOLD: assert property (s_wait |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped or moved before answer");
  AST_REQ_DROP: assert property (s_answer |=> !mem_req)
    else $error("memory request still high after answer");
  AST_ADDR_ALIGN: assert property (mem_req |-> mem_addr[2:0] == 3'h0)
    else $error("memory word address not aligned");
  AST_BUF_HOLD: assert property (s_offer |=> s_held)
    else $error("offered buffer changed while stalled");
  AST_BUF_DROP: assert property (s_take |=> s_quiet)
    else $error("buffer offer or fetch too soon after acceptance");
  AST_ORDER: assert property (buf_valid && wr_seen_r |-> buf_dev_writes)
    else $error("readable buffer after writable one");
  AST_FETCH_DONE: assert property ($rose(buf_valid) |-> !mem_req && !$past(mem_req))
    else $error("buffer offered while descriptor still fetching");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read cycle");
endmodule // walker_props

bind descriptor_chain_walker walker_props #(.QALIGN(QALIGN)) walker_props_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
  .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_addr(buf_addr), .buf_len(buf_len),
  .buf_dev_writes(buf_dev_writes), .buf_last(buf_last), .buf_head(buf_head)
);

`default_nettype wire

// >>> sim/guest_mem.sv
// Guest memory model answering the walker's word reads.
// Assumes the bench fills mem directly and sets the answer delay on lat.
`timescale 1ns/1ps
`default_nettype none

module guest_mem (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic [63:0] mem_addr,
  input wire logic [1:0] lat,
  output logic mem_rvalid,
  output logic [63:0] mem_rdata
);
  logic [63:0] mem [logic [63:0]];
  logic [1:0] wait_r;

  // Answer after lat cycles; data toggles when idle so stale words never pass
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= 64'h0;
      wait_r <= 2'h0;
    end else if (mem_req && !mem_rvalid && wait_r >= lat) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_rdata;
      wait_r <= 2'h0;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r <= (mem_req && !mem_rvalid) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule // guest_mem

`default_nettype wire

// >>> sim/descriptor_chain_walker_test.sv
// Self-checking bench: builds chains in guest memory and checks offered buffers.
// Assumes walker_pkg, the walker, its checker and guest_mem are compiled first.
`timescale 1ns/1ps
`default_nettype none

module descriptor_chain_walker_test;
  import walker_pkg::*;
  localparam logic [63:0] DBASE = 64'h1000;
  localparam logic [63:0] ABASE = 64'h2000;
  localparam logic [63:0] IBASE = 64'h3000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic buf_ready = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [REG_DW-1:0] reg_rdata;
  logic mem_req, mem_rvalid, buf_valid, buf_dev_writes, buf_last;
  logic [63:0] mem_addr, mem_rdata, buf_addr;
  logic [31:0] buf_len;
  logic [15:0] buf_head;
  logic [31:0] seed = 32'h5E28B3DF;
  int mismatches = 0;
  int checks_done = 0;
  logic [63:0] a [8];
  logic [31:0] l [8];

  always #5 sys_clk = ~sys_clk;

  descriptor_chain_walker descriptor_chain_walker_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_addr(buf_addr),
    .buf_len(buf_len), .buf_dev_writes(buf_dev_writes), .buf_last(buf_last), .buf_head(buf_head));
  guest_mem guest_mem_inst (.sys_clk(sys_clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////
  // Stimulus source and expectations
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Legacy used ring: after available ring tail, rounded up to alignment
  function automatic logic [31:0] used_lo(input logic [63:0] av, input logic [15:0] qs);
    logic [63:0] e;
    e = av + 64'h6 + {47'h0, qs, 1'b0} + 64'(QALIGN_DEF) - 64'h1;
    return 32'(e / 64'(QALIGN_DEF) * 64'(QALIGN_DEF));
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Register port
  task automatic wr(input logic [REG_AW-1:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_raw(input logic [REG_AW-1:0] ad, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic rd(input logic [REG_AW-1:0] ad, input logic [31:0] e);
    logic [31:0] d;
    rd_raw(ad, d);
    check({32'h0, d}, {32'h0, e});
  endtask

  // Poll one status bit, bounded
  task automatic wait_st(input int b, input logic v);
    logic [31:0] d;
    for (int n = 0; n < 100; n++) begin
      rd_raw(OFF_STATUS, d);
      if (d[b] === v) return;
    end
    mismatches++;
    end_of_test();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Guest memory writers; be selects byte-reversed fields
  task automatic put16(input logic [63:0] ad, input logic [15:0] v, input logic be);
    logic [63:0] w;
    w = {ad[63:3], 3'h0};
    if (!guest_mem_inst.mem.exists(w)) guest_mem_inst.mem[w] = 64'h0;
    guest_mem_inst.mem[w][ad[2:1]*16 +: 16] = be ? {v[7:0], v[15:8]} : v;
  endtask

  task automatic put_desc(input logic [63:0] tb, input logic [15:0] i, input logic [63:0] ad,
                          input logic [31:0] ln, input logic [15:0] fl, input logic [15:0] nx,
                          input logic be);
    logic [63:0] w;
    w = tb + {44'h0, i, 4'h0};
    if (be) begin
      guest_mem_inst.mem[w] = {<<8{ad}};
      guest_mem_inst.mem[w + 64'h8] = {16'({<<8{nx}}), 16'({<<8{fl}}), 32'({<<8{ln}})};
    end else begin
      guest_mem_inst.mem[w] = ad;
      guest_mem_inst.mem[w + 64'h8] = {nx, fl, ln};
    end
  endtask

  // Wait for an offer, compare, stall a random while, then accept
  task automatic take(input logic [63:0] ad, input logic [31:0] ln, input logic w,
                      input logic lst, input logic [15:0] hd);
    int n;
    logic [31:0] r;
    r = rnd();
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (buf_valid !== 1'b1 && n < 300);
    if (n >= 300) begin
      mismatches++;
      end_of_test();
    end
    check(buf_addr, ad);
    check({32'h0, buf_len}, {32'h0, ln});
    check({63'h0, buf_dev_writes}, {63'h0, w});
    check({47'h0, buf_last, buf_head}, {47'h0, lst, hd});
    repeat (r[3:2]) @(posedge sys_clk);
    @(posedge sys_clk);
    buf_ready <= 1'b1;
    lat <= r[1:0];
    @(posedge sys_clk);
    buf_ready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      a[i] = {rnd(), rnd()};
      l[i] = rnd();
    end
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFF_QSIZE, {16'h0, QSIZE_RST});
    rd(OFF_CTRL, 32'h0);
    wr(OFF_QSIZE, 32'h8);
    wr(OFF_QSIZE, 32'h3);
    rd(OFF_QSIZE, 32'h8);
    rd(8'h3C, 32'h0);
    wr(OFF_DESC_LO, DBASE[31:0]);
    wr(OFF_AVAIL_LO, ABASE[31:0]);
    // Readable then writable, linked out of order; no loops, within size
    put_desc(DBASE, 16'h2, a[0], l[0], FLAG_NEXT, 16'h5, 1'b0);
    put_desc(DBASE, 16'h5, a[1], l[1], FLAG_WRITE, 16'h0, 1'b0);
    put16(ABASE + 64'h4, 16'h2, 1'b0);
    put16(ABASE + 64'h2, 16'h1, 1'b0);
    wr(OFF_CTRL, 32'h9);
    wr(OFF_NOTIFY, 32'h1);
    take(a[0], l[0], 1'b0, 1'b0, 16'h2);
    take(a[1], l[1], 1'b1, 1'b1, 16'h2);
    wait_st(STAT_BUSY_BIT, 1'b0);
    rd(OFF_INDEX, 32'h0001_0001);
    // Plain descriptor then indirect table; table write flag must be ignored
    put_desc(DBASE, 16'h3, a[2], l[2], FLAG_NEXT, 16'h4, 1'b0);
    put_desc(DBASE, 16'h4, IBASE, 32'h30, FLAG_INDIRECT | FLAG_WRITE, 16'h0, 1'b0);
    put_desc(IBASE, 16'h0, a[3], l[3], FLAG_NEXT, 16'h2, 1'b0);
    put_desc(IBASE, 16'h2, a[4], l[4], FLAG_WRITE | FLAG_NEXT, 16'h1, 1'b0);
    put_desc(IBASE, 16'h1, a[5], l[5], FLAG_WRITE, 16'h0, 1'b0);
    put16(ABASE + 64'h6, 16'h3, 1'b0);
    put16(ABASE + 64'h2, 16'h2, 1'b0);
    wr(OFF_NOTIFY, 32'h1);
    take(a[2], l[2], 1'b0, 1'b0, 16'h3);
    take(a[3], l[3], 1'b0, 1'b0, 16'h3);
    take(a[4], l[4], 1'b1, 1'b0, 16'h3);
    take(a[5], l[5], 1'b1, 1'b1, 16'h3);
    wait_st(STAT_BUSY_BIT, 1'b0);
    rd(OFF_INDEX, 32'h0002_0002);
    // Writable before readable on purpose: walker must stop with code 7
    put_desc(DBASE, 16'h6, a[6], l[6], FLAG_WRITE | FLAG_NEXT, 16'h7, 1'b0);
    put_desc(DBASE, 16'h7, a[7], l[7], 16'h0, 16'h0, 1'b0);
    put16(ABASE + 64'h8, 16'h6, 1'b0);
    put16(ABASE + 64'h2, 16'h3, 1'b0);
    wr(OFF_NOTIFY, 32'h1);
    take(a[6], l[6], 1'b1, 1'b0, 16'h6);
    wait_st(STAT_ERR_BIT, 1'b1);
    rd(OFF_STATUS, 32'h73);
    // Legacy, guest big-endian: ring follows the table, fields byte-reversed
    put_desc(DBASE, 16'h1, a[0], l[0], FLAG_WRITE, 16'h0, 1'b1);
    put16(DBASE + 64'h84, 16'h1, 1'b1);
    put16(DBASE + 64'h82, 16'h1, 1'b1);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'hF);
    rd(OFF_USED_LO, used_lo(DBASE + 64'h80, 16'h8));
    wr(OFF_NOTIFY, 32'h1);
    take(a[0], l[0], 1'b1, 1'b1, 16'h1);
    // Indirect together with continue on purpose: walker must stop with code 4
    put_desc(DBASE, 16'h0, IBASE, 32'h30, FLAG_INDIRECT | FLAG_NEXT, 16'h1, 1'b1);
    put16(DBASE + 64'h86, 16'h0, 1'b1);
    put16(DBASE + 64'h82, 16'h2, 1'b1);
    wr(OFF_NOTIFY, 32'h1);
    wait_st(STAT_ERR_BIT, 1'b1);
    rd(OFF_STATUS, 32'h43);
    end_of_test();
  end
endmodule // descriptor_chain_walker_test

`default_nettype wire
